/* hw/static_zone_bus_timing.sv */
// Summary of operation
// - Wait field adds 0..7 internal wait cycles; ignored under fast read.
// - Hold field adds 0..3 hold cycles at end; ignored under fast read.
// - Burst enable bursts 16-bit reads on 8-bit zones, else ignored.
// - Burst-wait adds one burst wait cycle when bursting, not fast read.
// - Width bit: 0 is 8-bit, 1 is 16-bit; flash must be 16-bit.
// - Fast read finishes in one cycle unless idle cycles come first; normal read takes two or more.
// - Post-idle adds an idle cycle after when next zone differs.
// - Pre-idle adds an idle cycle before when zone differs from last.
// - Zone registers reset to 069F: 16-bit, seven waits, three holds.
// - Zones 1 and 2 are off-chip, each with its own select output.
// - Flash timing covers the program and data flash ranges.
// - Fast flash read is single cycle unless idle cycles come first; limits core clock.
// - Normal flash read waits field plus one, then holds.
// - Flash write under fast read: one wait, no hold.
// - Flash write: field plus one late, plus two early, then holds.
// - On-chip RAM single cycle unless a post idle owed by the last zone comes first.
// - Peripherals: one wait, one preliminary idle, no hold.
// - I/O expansion range uses the I/O zone register timing.
// - Burst enable has no effect in the flash zone.
// - Reset selects early write; software writes late write.
`timescale 1ns/1ps

module static_zone_bus_timing
    import zone_timing_pkg::*;
#(
    parameter int CLK_MHZ = 200      // Core clock rate in MHz.
) (
    input  wire logic                   core_clk,  // Core clock.
    input  wire logic                   rst_n,     // Sync reset, low.
    input  wire logic                   psel,      // APB select.
    input  wire logic                   penable,   // APB enable.
    input  wire logic                   pwrite,    // APB direction.
    input  wire logic [11:0]            paddr,     // APB byte address.
    input  wire logic [31:0]            pwdata,    // APB write data.
    input  wire logic [3:0]             pstrb,     // APB byte strobes.
    output logic      [31:0]            prdata,    // APB read data.
    output logic                        pready,    // APB ready.
    output logic                        pslverr,   // APB error.
    input  wire zone_timing_pkg::cpu_req_t cpu_req, // CPU request.
    output zone_timing_pkg::cpu_rsp_t   cpu_rsp    // CPU status.
);
    import zone_timing_pkg::*;

    logic [15:0] flash_zone_timing_cfg_reg;
    logic [15:0] ext_zone1_timing_cfg_reg;
    logic [15:0] ext_zone2_timing_cfg_reg;
    logic [15:0] io_zone_timing_cfg_reg;
    logic [7:0]  bus_unit_cfg_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    cpu_rsp_t    rsp_reg;
    cpu_rsp_t    rsp_next;
    seq_state_t  state_reg;
    seq_state_t  state_next;
    logic [3:0]  cnt_reg;
    logic [3:0]  cnt_next;
    logic [1:0]  hold_reg;
    logic [1:0]  hold_next;
    logic        burst_reg;
    logic        burst_next;
    logic        post_reg;
    logic        post_next;
    zone_id_t    last_zone_reg;
    zone_id_t    last_zone_next;
    zone_id_t    cur_zone_reg;
    zone_id_t    cur_zone_next;

    function automatic logic in_range(input logic [23:0] a,
                                      input logic [23:0] lo,
                                      input logic [23:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // APB decode; an access phase always takes two cycles, pready rising one cycle after penable.
    // A write lands only at the edge where the master sees pready high.
    wire        apb_access = psel && penable && !pready_reg;
    wire        apb_done   = psel && penable && pready_reg;
    wire        apb_wr     = apb_done && pwrite;
    wire [9:0]  reg_idx    = paddr[11:2];
    wire        hit_bus    = (reg_idx == {6'h00, IDX_BUS_UNIT});
    wire        hit_io     = (reg_idx == {6'h00, IDX_IO_ZONE});
    wire        hit_flash  = (reg_idx == {6'h00, IDX_FLASH_ZONE});
    wire        hit_z1     = (reg_idx == {6'h00, IDX_EXT_ZONE1});
    wire        hit_z2     = (reg_idx == {6'h00, IDX_EXT_ZONE2});
    wire        hit_any    = hit_bus | hit_io | hit_flash | hit_z1 | hit_z2;
    wire [15:0] wdata16    = pwdata[15:0];
    wire        lanes16    = pstrb[0] && pstrb[1];

    // Register read mux.
    logic [31:0] rd_mux;
    always_comb begin
        if (hit_bus) begin
            rd_mux = {24'h00_0000, bus_unit_cfg_reg};
        end else if (hit_io) begin
            rd_mux = {16'h0000, io_zone_timing_cfg_reg};
        end else if (hit_flash) begin
            rd_mux = {16'h0000, flash_zone_timing_cfg_reg};
        end else if (hit_z1) begin
            rd_mux = {16'h0000, ext_zone1_timing_cfg_reg};
        end else if (hit_z2) begin
            rd_mux = {16'h0000, ext_zone2_timing_cfg_reg};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    // Registers and APB answer. Zone writes need both low byte lanes; the bus unit register needs only lane 0.
    // reset values
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flash_zone_timing_cfg_reg <= ZONE_CFG_RESET;
            ext_zone1_timing_cfg_reg  <= ZONE_CFG_RESET;
            ext_zone2_timing_cfg_reg  <= ZONE_CFG_RESET;
            io_zone_timing_cfg_reg    <= ZONE_CFG_RESET;
            bus_unit_cfg_reg          <= BUS_UNIT_RESET;
            prdata_reg                <= 32'h0000_0000;
            pready_reg                <= 1'b0;
            pslverr_reg               <= 1'b0;
        end else begin
            pready_reg  <= apb_access;
            pslverr_reg <= apb_access && !hit_any;
            prdata_reg  <= (apb_access && !pwrite) ? rd_mux : 32'h0000_0000;
            if (apb_wr && lanes16) begin
                if (hit_flash) begin
                    flash_zone_timing_cfg_reg <= wdata16 & ZONE_CFG_MASK;
                end
                if (hit_z1) begin
                    ext_zone1_timing_cfg_reg <= wdata16 & ZONE_CFG_MASK;
                end
                if (hit_z2) begin
                    ext_zone2_timing_cfg_reg <= wdata16 & ZONE_CFG_MASK;
                end
                if (hit_io) begin
                    io_zone_timing_cfg_reg <= wdata16 & IO_CFG_MASK;
                end
            end
            if (apb_wr && pstrb[0] && hit_bus) begin
                bus_unit_cfg_reg <= pwdata[7:0] & BUS_UNIT_MASK;
            end
        end
    end

    // Zone decode of the CPU address.
    // flash ranges
    wire [23:0] a = cpu_req.addr;
    wire is_flash = in_range(a, PFLASH_LO, PFLASH_HI)
                  | in_range(a, DFLASH_LO, DFLASH_HI);
    wire is_ram   = in_range(a, RAM0_LO, RAM0_HI)
                  | in_range(a, RAM1_LO, RAM1_HI);
    wire is_io    = in_range(a, IOZ_LO, PER1_HI);
    wire is_per   = in_range(a, PER0_LO, PER0_HI)
                  | in_range(a, PER1_LO, PER1_HI);
    wire is_z1    = in_range(a, ZONE1_LO, ZONE1_HI);
    wire is_z2    = in_range(a, ZONE2_LO, ZONE2_HI);

    zone_id_t req_zone;
    assign req_zone = is_flash ? ZN_FLASH :
                      is_ram   ? ZN_RAM   :
                      is_io    ? ZN_IO    :
                      is_per   ? ZN_PERIPH :
                      is_z1    ? ZN_EXT1  :
                      is_z2    ? ZN_EXT2  : ZN_NONE;

    // Waits, holds and burst wait are sampled as the access starts; a later
    // write can only change a pre idle still due after a post idle.
    // sampled at start
    logic [15:0] zcfg;
    assign zcfg = (req_zone == ZN_FLASH) ? flash_zone_timing_cfg_reg :
                  (req_zone == ZN_EXT1)  ? ext_zone1_timing_cfg_reg  :
                  (req_zone == ZN_EXT2)  ? ext_zone2_timing_cfg_reg  :
                                           io_zone_timing_cfg_reg;

    wire [2:0] f_wait = zcfg[WAIT_LSB +: 3];
    wire [1:0] f_hold = zcfg[HOLD_LSB +: 2];
    wire       f_rbe  = zcfg[RBE_BIT];
    wire       f_wbr  = zcfg[WBR_BIT];
    wire       f_bw   = zcfg[BW_BIT];
    wire       f_post_idle_enable = zcfg[POST_IDLE_ENABLE_BIT];
    wire       f_pre_idle_enable = zcfg[PRE_IDLE_ENABLE_BIT];
    wire       f_fre  = zcfg[FRE_BIT] && (req_zone != ZN_IO);
    wire       early  = bus_unit_cfg_reg[EWR_BIT];
    wire       is_cfg = (req_zone == ZN_FLASH) || (req_zone == ZN_EXT1)
                      || (req_zone == ZN_EXT2) || (req_zone == ZN_IO);

    // burst only on 16-bit reads of 8-bit zones
    // width bit selects 8 or 16
    wire do_burst = is_cfg && (req_zone != ZN_FLASH) && !cpu_req.write
                  && cpu_req.word16 && !f_bw && f_rbe && !f_fre;
    wire burst_wait = do_burst && f_wbr;

    // Wait count per access class.
    // wait field
    // write field plus one or two
    logic [3:0] waits;
    logic [1:0] holds;
    logic       fixed_pre;
    always_comb begin
        waits     = 4'h0;
        holds     = 2'h0;
        fixed_pre = 1'b0;
        if (req_zone == ZN_RAM || req_zone == ZN_NONE) begin
            waits = 4'h0;
        end else if (req_zone == ZN_PERIPH) begin
            waits     = 4'h1;
            fixed_pre = 1'b1;
        end else if (f_fre && !cpu_req.write) begin
            waits = 4'h0;
        end else if (f_fre) begin
            waits = 4'h1;
        end else begin
            waits = {1'b0, f_wait} + 4'h1
                  + ((cpu_req.write && early) ? 4'h1 : 4'h0);
            holds = f_hold;
        end
    end

    wire zone_change = (last_zone_reg != ZN_NONE)
                     && (last_zone_reg != req_zone);
    wire need_pre = fixed_pre || (is_cfg && f_pre_idle_enable && zone_change);
    wire need_post = post_reg && zone_change;
    // The request still stands on the done cycle, so it must not be
    // taken a second time there.
    wire take = (state_reg == ST_IDLE) && cpu_req.valid && !rsp_reg.done;

    // Access sequencer.
    always_comb begin
        state_next     = state_reg;
        cnt_next       = cnt_reg;
        hold_next      = hold_reg;
        burst_next     = burst_reg;
        post_next      = post_reg;
        last_zone_next = last_zone_reg;
        cur_zone_next  = cur_zone_reg;
        rsp_next       = '0;
        case (state_reg)
            ST_IDLE: begin
                if (cpu_req.valid && !rsp_reg.done) begin
                    cnt_next      = waits;
                    hold_next     = holds;
                    burst_next    = burst_wait;
                    cur_zone_next = req_zone;
                    post_next     = is_cfg && f_post_idle_enable;
                    rsp_next.busy = 1'b1;
                    if (need_post || need_pre) begin
                        state_next = need_post ? ST_POST : ST_PRE;
                        rsp_next.idle_cycle = 1'b1;
                        cnt_next = waits;
                    end else if (waits != 4'h0) begin
                        state_next = ST_WAIT;
                    end else if (burst_wait) begin
                        state_next = ST_BURST;
                    end else if (holds != 2'h0) begin
                        state_next = ST_HOLD;
                    end else begin
                        rsp_next.done = 1'b1;
                        rsp_next.busy = 1'b0;
                        last_zone_next = req_zone;
                    end
                    rsp_next.zone1_select_out = (req_zone == ZN_EXT1)
                                              && !rsp_next.idle_cycle;
                    rsp_next.zone2_select_out = (req_zone == ZN_EXT2)
                                              && !rsp_next.idle_cycle;
                end
            end
            ST_POST, ST_PRE: begin
                rsp_next.busy = 1'b1;
                if (state_reg == ST_POST && need_pre) begin
                    state_next = ST_PRE;
                    rsp_next.idle_cycle = 1'b1;
                end else begin
                    state_next = (cnt_reg != 4'h0) ? ST_WAIT :
                                 burst_reg ? ST_BURST :
                                 (hold_reg != 2'h0) ? ST_HOLD : ST_IDLE;
                    rsp_next.zone1_select_out = (cur_zone_reg == ZN_EXT1);
                    rsp_next.zone2_select_out = (cur_zone_reg == ZN_EXT2);
                    if (state_next == ST_IDLE) begin
                        rsp_next.done  = 1'b1;
                        rsp_next.busy  = 1'b0;
                        last_zone_next = cur_zone_reg;
                    end
                end
            end
            ST_WAIT, ST_BURST, ST_HOLD: begin
                rsp_next.busy = 1'b1;
                rsp_next.zone1_select_out = (cur_zone_reg == ZN_EXT1);
                rsp_next.zone2_select_out = (cur_zone_reg == ZN_EXT2);
                if (state_reg == ST_WAIT) begin
                    cnt_next = cnt_reg - 4'h1;
                end else if (state_reg == ST_BURST) begin
                    burst_next = 1'b0;
                end else begin
                    hold_next = hold_reg - 2'h1;
                end
                state_next = (cnt_next != 4'h0) ? ST_WAIT :
                             burst_next ? ST_BURST :
                             (hold_next != 2'h0) ? ST_HOLD : ST_IDLE;
                if (state_next == ST_IDLE) begin
                    rsp_next.done  = 1'b1;
                    rsp_next.busy  = 1'b0;
                    last_zone_next = cur_zone_reg;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_reg     <= ST_IDLE;
            cnt_reg       <= 4'h0;
            hold_reg      <= 2'h0;
            burst_reg     <= 1'b0;
            post_reg      <= 1'b0;
            last_zone_reg <= ZN_NONE;
            cur_zone_reg  <= ZN_NONE;
            rsp_reg       <= '0;
        end else begin
            state_reg     <= state_next;
            cnt_reg       <= cnt_next;
            hold_reg      <= hold_next;
            burst_reg     <= burst_next;
            post_reg      <= post_next;
            last_zone_reg <= last_zone_next;
            cur_zone_reg  <= cur_zone_next;
            rsp_reg       <= rsp_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign cpu_rsp = rsp_reg;

    // Assertions.
    sequence s_start_ram;
        take && req_zone == ZN_RAM;
    endsequence
    property p_ram_one;
        @(posedge core_clk) disable iff (!rst_n)
        s_start_ram |=> cpu_rsp.done;
    endproperty
    a_ram_one: assert property (p_ram_one)
        else $error("ram not single");
    property p_fast_read;
        @(posedge core_clk) disable iff (!rst_n)
        (take && req_zone == ZN_FLASH
         && f_fre && !cpu_req.write && !need_pre && !need_post)
        |=> cpu_rsp.done;
    endproperty
    a_fast_read: assert property (p_fast_read)
        else $error("fast read slow");
    property p_norm_read;
        @(posedge core_clk) disable iff (!rst_n)
        (take && req_zone == ZN_FLASH
         && !f_fre && !cpu_req.write) |=> !cpu_rsp.done;
    endproperty
    a_norm_read: assert property (p_norm_read)
        else $error("normal read short");
    property p_wait_load;
        @(posedge core_clk) disable iff (!rst_n)
        (take && is_cfg && !f_fre)
        |=> cnt_reg >= 4'h1;
    endproperty
    a_wait_load: assert property (p_wait_load)
        else $error("wait missing");
    property p_fast_write;
        @(posedge core_clk) disable iff (!rst_n)
        (take && req_zone == ZN_FLASH
         && f_fre && cpu_req.write) |=> cnt_reg == 4'h1 && hold_reg == 2'h0;
    endproperty
    a_fast_write: assert property (p_fast_write)
        else $error("fast write");
    property p_sel_excl;
        @(posedge core_clk) disable iff (!rst_n)
        !(cpu_rsp.zone1_select_out && cpu_rsp.zone2_select_out);
    endproperty
    a_sel_excl: assert property (p_sel_excl)
        else $error("both selects");
    // peripheral pre idle; an owed post idle would add a cycle.
    property p_per_idle;
        @(posedge core_clk) disable iff (!rst_n)
        (take && req_zone == ZN_PERIPH && !need_post)
        |=> cpu_rsp.idle_cycle ##1 !cpu_rsp.done ##1 cpu_rsp.done;
    endproperty
    a_per_idle: assert property (p_per_idle)
        else $error("peripheral timing");
    property p_reset_val;
        @(posedge core_clk)
        !rst_n |=> flash_zone_timing_cfg_reg == ZONE_CFG_RESET;
    endproperty
    a_reset_val: assert property (p_reset_val)
        else $error("reset value");

endmodule // static_zone_bus_timing

/* pkg/zone_timing_pkg.sv */
package zone_timing_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [3:0] IDX_BUS_UNIT   = 4'h0;
    localparam logic [3:0] IDX_IO_ZONE    = 4'h1;
    localparam logic [3:0] IDX_FLASH_ZONE = 4'h2;
    localparam logic [3:0] IDX_EXT_ZONE1  = 4'h3;
    localparam logic [3:0] IDX_EXT_ZONE2  = 4'h4;

    // Reset values of the configuration registers.
    localparam logic [15:0] ZONE_CFG_RESET = 16'h069f;
    localparam logic [7:0]  BUS_UNIT_RESET = 8'h07;

    // Field positions inside a zone configuration word; EWR_BIT sits in the bus unit register.
    localparam int WAIT_LSB   = 0;
    localparam int HOLD_LSB   = 3;
    localparam int RBE_BIT    = 5;
    localparam int WBR_BIT    = 6;
    localparam int BW_BIT     = 7;
    localparam int POST_IDLE_ENABLE_BIT   = 9;
    localparam int PRE_IDLE_ENABLE_BIT   = 10;
    localparam int FRE_BIT    = 11;
    localparam int EWR_BIT    = 0;

    // Writable bits of each register; the rest read as zero, save I/O bit 10, which reset sets.
    localparam logic [15:0] ZONE_CFG_MASK = 16'h0eff;
    localparam logic [15:0] IO_CFG_MASK   = 16'h02ff;
    localparam logic [7:0]  BUS_UNIT_MASK = 8'h07;

    // CPU address map, 24-bit byte addresses.
    localparam logic [23:0] PFLASH_LO = 24'h00_0000;
    localparam logic [23:0] PFLASH_HI = 24'h03_ffff;
    localparam logic [23:0] DFLASH_LO = 24'h0e_0000;
    localparam logic [23:0] DFLASH_HI = 24'h0e_1fff;
    localparam logic [23:0] RAM0_LO   = 24'h0e_8000;
    localparam logic [23:0] RAM0_HI   = 24'h0e_91ff;
    localparam logic [23:0] RAM1_LO   = 24'h0e_c000;
    localparam logic [23:0] RAM1_HI   = 24'h0e_ebff;
    localparam logic [23:0] PER0_LO   = 24'h0e_f000;
    localparam logic [23:0] PER0_HI   = 24'h0e_f1ff;
    localparam logic [23:0] PER1_LO   = 24'hff_0000;
    localparam logic [23:0] PER1_HI   = 24'hff_fbff;
    localparam logic [23:0] IOZ_LO    = 24'hff_fb00;
    localparam logic [23:0] ZONE1_LO  = 24'h40_0000;
    localparam logic [23:0] ZONE1_HI  = 24'h7f_ffff;
    localparam logic [23:0] ZONE2_LO  = 24'h80_0000;
    localparam logic [23:0] ZONE2_HI  = 24'hfe_ffff;

    // Fast flash reads limit the core clock, in MHz.
    localparam int FAST_READ_MAX_MHZ = 24;

    // Zone identifiers used for idle-cycle decisions.
    typedef enum logic [2:0] {
        ZN_FLASH = 3'h0,
        ZN_EXT1  = 3'h1,
        ZN_EXT2  = 3'h2,
        ZN_RAM   = 3'h3,
        ZN_PERIPH = 3'h4,
        ZN_IO    = 3'h5,
        ZN_NONE  = 3'h6
    } zone_id_t;

    // Access sequencer states, Gray coded in the order listed.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRE  = 3'b001,
        ST_WAIT = 3'b011,
        ST_BURST = 3'b010,
        ST_HOLD = 3'b110,
        ST_POST = 3'b111
    } seq_state_t;

    // One CPU bus request.
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        word16;
        logic [23:0] addr;
    } cpu_req_t;

    // Status towards the CPU and the external memory pins.
    typedef struct packed {
        logic done;
        logic busy;
        logic zone1_select_out;
        logic zone2_select_out;
        logic idle_cycle;
    } cpu_rsp_t;

endpackage

/* test/cpu_bus_model.sv */
`timescale 1ns/1ps

// Core bus master; holds each request whole until done is seen.
module cpu_bus_model
    import zone_timing_pkg::*;
(
    input  wire logic                   core_clk, // Core clock.
    input  wire logic                   rst_n,    // Sync reset, low.
    input  wire logic                   start,    // Begin one access.
    input  wire logic                   wr,       // Access is a write.
    input  wire logic [23:0]            addr,     // Access address.
    input  wire zone_timing_pkg::cpu_rsp_t cpu_rsp, // Status in.
    output zone_timing_pkg::cpu_req_t   cpu_req,  // Request out.
    output int                          lat,      // Cycles to done.
    output logic                        fin,      // Finished pulse.
    output logic                        sel_seen, // Select was seen.
    output int                          idles     // Idle cycles seen.
);
    import zone_timing_pkg::*;
    int cnt;
    // A released address shows its inverse so stale values never match.
    always @(posedge core_clk) begin
        fin <= 1'b0;
        if (!rst_n) begin
            cpu_req <= '0;
        end else if (start) begin
            cpu_req <= '{1'b1, wr, 1'b1, addr};
            cnt <= 0;
            sel_seen <= 1'b0;
            idles <= 0;
        end else if (cpu_req.valid) begin
            sel_seen <= sel_seen | cpu_rsp.zone1_select_out
                        | cpu_rsp.zone2_select_out;
            idles <= idles + int'(cpu_rsp.idle_cycle);
            cnt <= cnt + 1;
            if (cpu_rsp.done) begin
                cpu_req <= '{1'b0, ~cpu_req.write, 1'b0, ~cpu_req.addr};
                lat <= cnt;
                fin <= 1'b1;
            end
        end
    end
endmodule // cpu_bus_model

/* test/static_zone_bus_timing_tb.sv */
`timescale 1ns/1ps

module static_zone_bus_timing_tb;
    import zone_timing_pkg::*;
    logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic start = 0, wr = 0, pready, pslverr, fin, sel_seen, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [23:0] addr = '0;
    logic [15:0] v;
    cpu_req_t cpu_req;
    cpu_rsp_t cpu_rsp;
    int lat, idles, errors = 0, n_compared = 0, cyc = 0;

    always #2.5 core_clk = ~core_clk;

    static_zone_bus_timing uut (.core_clk(core_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cpu_req(cpu_req), .cpu_rsp(cpu_rsp));
    cpu_bus_model cpu (.core_clk(core_clk), .rst_n(rst_n), .start(start),
        .wr(wr), .addr(addr), .cpu_rsp(cpu_rsp), .cpu_req(cpu_req),
        .lat(lat), .fin(fin), .sel_seen(sel_seen), .idles(idles));

    // Reference timing: base cycle, waits, burst wait, then holds.
    function automatic int exp_lat(logic [15:0] c, logic w, logic e);
        if (c[FRE_BIT]) return w ? 2 : 1;
        return 2 + int'(c[2:0]) + int'(c[4:3]) + (w ? int'(e) : 0)
            + int'(!w && c[RBE_BIT] && c[WBR_BIT] && !c[BW_BIT]);
    endfunction

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; pready is read before the edge's own updates land.
    task automatic apb(logic w, int idx, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= 12'(idx * 4);
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
        @(posedge core_clk);
    endtask

    task automatic acc(logic w, logic [23:0] a, int exp, string what);
        start <= 1'b1;
        wr <= w;
        addr <= a;
        @(posedge core_clk);
        start <= 1'b0;
        do begin
            @(posedge core_clk);
        end while (fin !== 1'b1);
        chk(what, 32'(lat), 32'(exp));
    endtask

    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // The run is cut short if a wait hangs.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'ha5499dc0));
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, i, '0);
            chk("reset value", rd, (i == 0) ? 32'h07 : 32'h069f);
        end
        apb(1'b0, 5, '0);
        chk("unmapped err", 32'(err), 32'h1);
        // Early write is still selected from reset.
        acc(1'b1, PFLASH_LO, exp_lat(ZONE_CFG_RESET, 1, 1), "early wr");
        // Late write is what normal operation needs.
        apb(1'b1, IDX_BUS_UNIT, 32'h06);
        // Flash idle bits kept clear and width kept at 16 bits.
        repeat (12) begin
            v = (16'($urandom) & ZONE_CFG_MASK & 16'hf9ff) | 16'h0080;
            apb(1'b1, IDX_FLASH_ZONE, 32'(v));
            apb(1'b0, IDX_FLASH_ZONE, '0);
            chk("flash cfg", rd, 32'(v));
            acc(0, DFLASH_LO + 24'($urandom % 32'h2000), exp_lat(v, 0, 0),
                "flash rd");
            acc(1, PFLASH_LO + 24'($urandom % 32'h4_0000), exp_lat(v, 1, 0),
                "flash wr");
        end
        acc(1'b0, RAM0_LO, 1, "ram rd");
        acc(1'b1, RAM1_HI, 1, "ram wr");
        acc(1'b0, PER0_LO, 3, "periph rd");
        // Zone 1 has both idle bits; zone 2 reads fast.
        apb(1'b1, IDX_EXT_ZONE1, 32'h0680);
        apb(1'b1, IDX_EXT_ZONE2, 32'h0880);
        acc(1'b0, ZONE1_LO, 3, "zone1 pre idle");
        chk("zone1 select", 32'(sel_seen), 32'h1);
        acc(1'b0, ZONE1_HI, 2, "zone1 same zone");
        acc(1'b0, ZONE2_LO, 2, "zone2 post idle");
        chk("zone2 idles", 32'(idles), 32'h1);
        chk("zone2 select", 32'(sel_seen), 32'h1);
        apb(1'b1, IDX_EXT_ZONE2, 32'h0060);
        acc(1'b0, ZONE2_HI, 3, "burst wait");
        apb(1'b1, IDX_EXT_ZONE2, 32'h0020);
        acc(1'b0, ZONE2_LO, 2, "burst no wait");
        // The I/O range follows its own register, not the fixed timing.
        apb(1'b1, IDX_IO_ZONE, 32'h0080);
        acc(1'b0, IOZ_LO, 2, "io zone");
        wrap_up();
    end
endmodule // static_zone_bus_timing_tb
